//--- hw/sclk_pkg.sv
// package: register map, field layout and timing constants of the sleep clock slot and seconds block
package sclk_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SLOT_W = 4;
	localparam int SECS_W = 32;
	localparam logic [7:0] ADDR_SLEEP_CLK_SLOTS = 8'h5F;
	localparam logic [7:0] ADDR_SECS_BYTE3 = 8'h70;
	localparam logic [7:0] ADDR_SECS_BYTE2 = 8'h71;
	localparam logic [7:0] ADDR_SECS_BYTE1 = 8'h72;
	localparam logic [7:0] ADDR_SECS_BYTE0 = 8'h73;
	localparam int WAKE_HI = 7;
	localparam int WAKE_LO = 4;
	localparam int SLEEP_HI = 3;
	localparam int SLEEP_LO = 0;
	localparam logic [3:0] SLOT_NONE = 4'h0;
	localparam logic [31:0] SECS_RESET = 32'h00000000;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int CLK_HZ = 40000000;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_S;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sclk_req_t;
	typedef enum logic [1:0] {
		SCLK_IDLE,
		SCLK_WAKE,
		SCLK_SLEEP
	} sclk_seq_t;
endpackage

//--- hw/sclk_regs.sv
// module: sleep clock-out slot register, seconds counter and clock-out control
`timescale 1ns/1ps
module sclk_regs
	import sclk_pkg::*;
#(
	parameter int TICK_COUNT = sclk_pkg::TICK_CYCLES
)(
	input wire logic mclk,
	input wire logic rst_b,
	input wire sclk_pkg::sclk_req_t req,
	output logic [7:0] rdata,
	input wire logic [7:0] nvm_slots,
	input wire logic nvm_valid,
	input wire logic sequencing_lock_group,
	input wire logic rtc_locked,
	input wire logic wake_start,
	input wire logic sleep_start,
	input wire logic slot_tick,
	input wire logic battery_hold_state,
	input wire logic safe_off_state,
	output logic low_freq_clock_out_en,
	output logic [31:0] seconds_count,
	output logic [3:0] seq_slot
);
	import sclk_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] slots_reg, slots_next;
	logic loaded_reg, loaded_next;
	logic [31:0] secs_reg, secs_next;
	logic [31:0] div_reg, div_next;
	logic [7:0] rdata_reg, rdata_next;
	logic clk_en_reg, clk_en_next;
	logic [3:0] slot_reg, slot_next;
	sclk_seq_t seq_reg, seq_next;
	logic tick;
	logic [3:0] wake_slot_select, sleep_slot_select;

	assign wake_slot_select = slots_reg[WAKE_HI:WAKE_LO];
	assign sleep_slot_select = slots_reg[SLEEP_HI:SLEEP_LO];
	assign tick = (div_reg == TICK_COUNT - 1);

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_comb
	begin
		slots_next = slots_reg;
		loaded_next = loaded_reg;
		secs_next = secs_reg;
		div_next = tick ? '0 : div_reg + 32'h00000001;
		rdata_next = rdata_reg;
		// nvm image is taken once after release, never in the reset branch
		if (!loaded_reg && nvm_valid)
		begin
			slots_next = nvm_slots;
			loaded_next = 1'b1;
		end
		if (req.wr && req.addr == ADDR_SLEEP_CLK_SLOTS && !sequencing_lock_group)
			slots_next = req.wdata;
		if (tick)
			secs_next = secs_reg + 32'h00000001;
		// an unlocked host write replaces its byte of a tick landing in the same cycle
		if (req.wr && !rtc_locked)
		begin
			unique case (req.addr)
				ADDR_SECS_BYTE3: secs_next[31:24] = req.wdata;
				ADDR_SECS_BYTE2: secs_next[23:16] = req.wdata;
				ADDR_SECS_BYTE1: secs_next[15:8] = req.wdata;
				ADDR_SECS_BYTE0: secs_next[7:0] = req.wdata;
				default: ;
			endcase
		end
		if (req.rd)
		begin
			unique case (req.addr)
				ADDR_SLEEP_CLK_SLOTS: rdata_next = slots_reg;
				ADDR_SECS_BYTE3: rdata_next = secs_reg[31:24];
				ADDR_SECS_BYTE2: rdata_next = secs_reg[23:16];
				ADDR_SECS_BYTE1: rdata_next = secs_reg[15:8];
				ADDR_SECS_BYTE0: rdata_next = secs_reg[7:0];
				default: rdata_next = READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			slots_reg <= 8'h00;
			loaded_reg <= 1'b0;
			secs_reg <= SECS_RESET;
			div_reg <= 32'h00000000;
			rdata_reg <= 8'h00;
		end
		else
		begin
			slots_reg <= slots_next;
			loaded_reg <= loaded_next;
			secs_reg <= secs_next;
			div_reg <= div_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// clock-out slot sequencing
	// ----------------------------------------
	always_comb
	begin
		seq_next = seq_reg;
		slot_next = slot_reg;
		clk_en_next = clk_en_reg;
		unique case (seq_reg)
			SCLK_IDLE:
			begin
				slot_next = 4'h0;
				if (wake_start && wake_slot_select != SLOT_NONE)
					seq_next = SCLK_WAKE;
				else if (sleep_start && sleep_slot_select != SLOT_NONE)
					seq_next = SCLK_SLEEP;
			end
			SCLK_WAKE:
				if (slot_tick)
				begin
					slot_next = slot_reg + 4'h1;
					if (slot_next == wake_slot_select)
					begin
						clk_en_next = 1'b1;
						seq_next = SCLK_IDLE;
					end
				end
			SCLK_SLEEP:
				if (slot_tick)
				begin
					slot_next = slot_reg + 4'h1;
					if (slot_next == sleep_slot_select)
					begin
						clk_en_next = 1'b0;
						seq_next = SCLK_IDLE;
					end
				end
		endcase
		if (battery_hold_state || safe_off_state)
		begin
			clk_en_next = 1'b0;
			seq_next = SCLK_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			seq_reg <= SCLK_IDLE;
			slot_reg <= 4'h0;
			clk_en_reg <= 1'b0;
		end
		else
		begin
			seq_reg <= seq_next;
			slot_reg <= slot_next;
			clk_en_reg <= clk_en_next;
		end
	end

	assign rdata = rdata_reg;
	assign low_freq_clock_out_en = clk_en_reg;
	assign seconds_count = secs_reg;
	assign seq_slot = slot_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	AST_WAKE_NONE: assert property ((seq_reg == SCLK_IDLE && wake_start
		&& wake_slot_select == SLOT_NONE && !sleep_start) |=> seq_reg == SCLK_IDLE)
		else $error("wake with zero slot started a sequence");
	AST_WAKE_EN: assert property ((seq_reg == SCLK_WAKE && slot_tick
		&& slot_reg + 4'h1 == wake_slot_select
		&& !battery_hold_state && !safe_off_state) |=> clk_en_reg)
		else $error("clock output not enabled in wake slot");
	AST_FORCE_LOW: assert property ((battery_hold_state || safe_off_state)
		|=> !clk_en_reg)
		else $error("clock output not low in hold or safe off");
	AST_HOLD: assert property ((seq_reg == SCLK_IDLE && !battery_hold_state
		&& !safe_off_state) |=> $stable(clk_en_reg))
		else $error("clock output changed while idle");
	AST_SLEEP_DIS: assert property ((seq_reg == SCLK_SLEEP && slot_tick
		&& slot_reg + 4'h1 == sleep_slot_select) |=> !clk_en_reg)
		else $error("clock output not disabled in sleep slot");
	AST_SLOT_LOCK: assert property ((req.wr && req.addr == ADDR_SLEEP_CLK_SLOTS
		&& sequencing_lock_group && loaded_reg) |=> $stable(slots_reg))
		else $error("locked slot register changed");
	AST_SLOT_WR: assert property ((req.wr && req.addr == ADDR_SLEEP_CLK_SLOTS
		&& !sequencing_lock_group) |=> slots_reg == $past(req.wdata))
		else $error("slot register write lost");
	// the release edge still holds the flops, so the load is judged one edge later
	AST_NVM: assert property ((rst_b && !loaded_reg && nvm_valid && !req.wr)
		|=> slots_reg == $past(nvm_slots))
		else $error("nvm image not loaded");
	AST_RD_MSB: assert property ((req.rd && req.addr == ADDR_SECS_BYTE3)
		|=> rdata_reg == $past(secs_reg[31:24]))
		else $error("byte3 read wrong");
	AST_TICK: assert property ((tick && !req.wr)
		|=> secs_reg == $past(secs_reg) + 32'h00000001)
		else $error("seconds did not advance");
	AST_RTC_LOCK: assert property ((rtc_locked && !tick) |=> $stable(secs_reg))
		else $error("locked counter changed");

	COV_WAKE: cover property (seq_reg == SCLK_WAKE ##[1:40] clk_en_reg);
	COV_SLEEP: cover property (seq_reg == SCLK_SLEEP ##[1:40] !clk_en_reg);
	COV_FORCE: cover property (clk_en_reg ##1 battery_hold_state);
	COV_WRSEC: cover property (req.wr && req.addr == ADDR_SECS_BYTE0 && !rtc_locked);
endmodule

//--- tb/sclk_host.sv
// host controller model issuing single-byte register accesses
`timescale 1ns/1ps
module sclk_host (
	input wire logic mclk,
	output sclk_pkg::sclk_req_t req,
	input wire logic [7:0] rdata
);
	import sclk_pkg::*;
	initial req = '0;
	// released addr and wdata are inverted, wr and rd dropped, so stale values never pass for fresh ones
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// single-byte register write, one xfer per call
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		xfer(1'b0, a, 8'h00);
		@(negedge mclk);
		d = rdata;
	endtask
endmodule

//--- tb/sleep_clkout_slot_and_rtc_time_tb.sv
// bench for slot register, seconds counter and clock-out enable
`timescale 1ns/1ps
module sleep_clkout_slot_and_rtc_time_tb;
	import sclk_pkg::*;
	// short second keeps the run brief
	localparam int TICKS = 50;
	logic mclk, rst_b, sequencing_lock_group, rtc_locked, wake_start, sleep_start, slot_tick, en;
	logic battery_hold_state, safe_off_state;
	logic [7:0] rdata, rv;
	logic [31:0] secs, s;
	logic [3:0] slot;
	sclk_req_t req;
	int mismatches = 0;
	int n_tests = 0;
	sclk_regs #(.TICK_COUNT(TICKS)) i_sclk_regs (.mclk(mclk), .rst_b(rst_b), .req(req),
		.rdata(rdata), .nvm_slots(8'h21), .nvm_valid(1'b1),
		.sequencing_lock_group(sequencing_lock_group),
		.rtc_locked(rtc_locked), .wake_start(wake_start), .sleep_start(sleep_start),
		.slot_tick(slot_tick), .battery_hold_state(battery_hold_state),
		.safe_off_state(safe_off_state), .low_freq_clock_out_en(en),
		.seconds_count(secs), .seq_slot(slot));
	sclk_host i_sclk_host (.mclk(mclk), .req(req), .rdata(rdata));
	task automatic chk_v(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_b(input string n, input logic e);
		chk_v(n, {31'h0, e}, {31'h0, en});
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// waits for the next seconds step, bounded
	task automatic sync;
		@(negedge mclk);
		s = secs;
		for (int i = 0; i < 2 * TICKS && secs === s; i++) @(negedge mclk);
	endtask
	task automatic seq(input bit wake, input int n, input int k);
		@(posedge mclk);
		wake_start <= wake;
		sleep_start <= !wake;
		@(posedge mclk);
		wake_start <= 1'b0;
		sleep_start <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk);
			slot_tick <= 1'b1;
			@(posedge mclk);
			slot_tick <= 1'b0;
			@(negedge mclk);
			if (i == 0)
				chk_v("slot", k, slot);
		end
		repeat (2) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic hold_low(input bit b);
		@(posedge mclk);
		battery_hold_state <= b;
		safe_off_state <= !b;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk_b("forced", 1'b0);
		@(posedge mclk);
		battery_hold_state <= 1'b0;
		safe_off_state <= 1'b0;
	endtask
	task automatic t_reset;
		chk_v("secs0", 32'h0, secs);
		i_sclk_host.rd(ADDR_SLEEP_CLK_SLOTS, rv);
		chk_v("slots", 8'h21, rv);
		i_sclk_host.rd(8'h60, rv);
		chk_v("unmapped", READ_UNMAPPED, rv);
	endtask
	task automatic t_secs;
		int c;
		sync();
		for (int i = 0; i < 4; i++) i_sclk_host.wr(ADDR_SECS_BYTE3 + 8'(i), 8'(8'h12 + 8'h22 * i));
		@(negedge mclk);
		chk_v("secs", 32'h12345678, secs);
		i_sclk_host.rd(ADDR_SECS_BYTE1, rv);
		chk_v("byte1", 8'h56, rv);
		i_sclk_host.rd(ADDR_SECS_BYTE3, rv);
		chk_v("byte3", 8'h12, rv);
		sync();
		chk_v("step", 32'h12345679, secs);
		c = 0;
		while (secs === 32'h12345679 && c < 2 * TICKS)
		begin
			@(negedge mclk);
			c++;
		end
		chk_v("period", TICKS, c);
	endtask
	task automatic t_lock;
		@(posedge mclk);
		sequencing_lock_group <= 1'b1;
		rtc_locked <= 1'b1;
		i_sclk_host.wr(ADDR_SLEEP_CLK_SLOTS, 8'h00);
		i_sclk_host.rd(ADDR_SLEEP_CLK_SLOTS, rv);
		chk_v("locked slots", 8'h21, rv);
		sync();
		i_sclk_host.wr(ADDR_SECS_BYTE0, 8'hF0);
		@(negedge mclk);
		chk_v("locked secs", s + 32'h1, secs);
		@(posedge mclk);
		sequencing_lock_group <= 1'b0;
		rtc_locked <= 1'b0;
	endtask
	task automatic t_seq;
		seq(1, 2, 1);
		chk_b("wake 2", 1'b1);
		seq(0, 1, 1);
		chk_b("sleep 1", 1'b0);
		seq(1, 2, 1);
		hold_low(1'b1);
		i_sclk_host.wr(ADDR_SLEEP_CLK_SLOTS, 8'h20);
		seq(1, 2, 1);
		seq(0, 3, 0);
		chk_b("sleep none", 1'b1);
		hold_low(1'b0);
		i_sclk_host.wr(ADDR_SLEEP_CLK_SLOTS, 8'h01);
		seq(1, 3, 0);
		chk_b("wake none", 1'b0);
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// all scenarios together stay well under this span
	initial
	begin
		#(25 * 20000);
		mismatches++;
		complete_run();
	end
	initial
	begin
		{rst_b, sequencing_lock_group, rtc_locked, wake_start, sleep_start, slot_tick} = '0;
		{battery_hold_state, safe_off_state} = '0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_secs();
		t_lock();
		t_seq();
		complete_run();
	end
endmodule
